/* hrs_sequencer.sv */
// Purpose: homing run sequencer with AHB-Lite registers
// Assumes: encoder position counted elsewhere, pins asynchronous
// Notes:   motion command outputs speed/accel/jerk carry the jerk/speed/accel words of active phase
`timescale 1ns/1ps
`default_nettype none
`include "hrs_map.svh"
module hrs_sequencer #(
    parameter int unsigned TICK_CYC = `HRS_TICK_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        limit_pos,
    input  wire logic        limit_neg,
    input  wire logic        ref_switch,
    input  wire logic        index_main,
    input  wire logic        secondary_index_track_input,
    input  wire logic        drive_enable,
    input  wire logic        commutation_found,
    input  wire logic        load_integral_rise,
    input  wire logic [31:0] actual_pos,
    output logic             move_active,
    output logic             move_dir_pos,
    output logic      [31:0] move_speed,
    output logic      [31:0] move_accel,
    output logic      [31:0] move_jerk,
    output logic      [31:0] move_target,
    output logic             move_to_target,
    output logic             pos_set,
    output logic      [31:0] pos_set_value,
    output logic             sync_disable,
    output logic             homing_done,
    output logic             homing_error,
    output logic             enc_offset_save,
    output logic      [31:0] enc_offset_value
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: three stages, change when stages two and three agree
    localparam int NIN = 5;
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] s1_r;
    logic [NIN-1:0] s2_r;
    logic [NIN-1:0] s3_r;
    logic [NIN-1:0] clean_r;
    logic [2:0]     drv_s1_r;
    logic [2:0]     drv_s2_r;
    logic [2:0]     drv_s3_r;
    logic [2:0]     drv_r;
    hrs_pkg::hrs_inputs_s in_s;

    assign pin_raw = {limit_pos, limit_neg, ref_switch, index_main,
                      secondary_index_track_input};

    generate
        for (genvar g = 0; g < NIN; g++) begin : g_sync
            // one synchroniser per switch or index pin
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_r[g]    <= 1'b0;
                    s2_r[g]    <= 1'b0;
                    s3_r[g]    <= 1'b0;
                    clean_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        clean_r[g] <= s3_r[g];
                    end
                end
            end
        end
        for (genvar g = 0; g < 3; g++) begin : g_dsync
            // drive-side status lines cross the same way
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    drv_s1_r[g] <= 1'b0;
                    drv_s2_r[g] <= 1'b0;
                    drv_s3_r[g] <= 1'b0;
                    drv_r[g]    <= 1'b0;
                end else begin
                    drv_s1_r[g] <= (g == 0) ? drive_enable :
                                   (g == 1) ? commutation_found : load_integral_rise;
                    drv_s2_r[g] <= drv_s1_r[g];
                    drv_s3_r[g] <= drv_s2_r[g];
                    if (drv_s2_r[g] == drv_s3_r[g]) begin
                        drv_r[g] <= drv_s3_r[g];
                    end
                end
            end
        end
    endgenerate

    assign in_s = clean_r;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl_r;
    logic [31:0] tmo_r;
    logic [31:0] dist_r;
    logic [31:0] offset_r;
    logic [31:0] poslim_r;
    logic        done_r;
    logic        err_tmo_r;
    logic        err_dist_r;
    logic        first_en_pend_r;
    logic        home_req_r;
    logic [31:0] tick_cnt_r;
    logic [31:0] tmo_cnt_r;
    logic [31:0] dist_acc_r;
    logic [31:0] start_pos_r;
    logic [31:0] last_pos_r;
    logic        en_d_r;
    logic        comm_d_r;
    logic        idx_d_r;
    logic        ref_d_r;
    hrs_pkg::hrs_state_e state_r;
    hrs_pkg::hrs_state_e state_nxt;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave decode
    logic        ph_wr_r;
    logic        ph_rd_r;
    logic [11:0] ph_addr_r;
    logic        a_valid;
    logic        wr_now;
    logic [11:0] wa;
    logic        sel_ctrl;
    logic        sel_tmo;
    logic        sel_dist;
    logic        sel_off;
    logic        sel_lim;
    logic        sel_prof;
    logic [3:0]  prof_idx;
    logic [3:0]  rd_idx;
    logic [31:0] prof_rdata;
    logic        rd_prof;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    assign a_valid  = hsel && hready && htrans[1] && (hsize == 3'h2);
    assign wr_now   = ph_wr_r;
    assign wa       = ph_addr_r;
    assign sel_ctrl = (wa == `HRS_OFF_CTRL);
    assign sel_tmo  = (wa == `HRS_OFF_TMO);
    assign sel_dist = (wa == `HRS_OFF_DIST);
    assign sel_off  = (wa == `HRS_OFF_OFFSET);
    assign sel_lim  = (wa == `HRS_OFF_POSLIM);
    assign sel_prof = (wa >= `HRS_OFF_SPEED0) && (wa < `HRS_OFF_POS);
    assign prof_idx = 4'((wa - `HRS_OFF_SPEED0) >> 2);
    // profile word picked by phase, or by the bus on a read request
    assign rd_idx   = rd_prof ? 4'((haddr - `HRS_OFF_SPEED0) >> 2) : 4'h0;
    assign rd_prof  = a_valid && !hwrite && (haddr >= `HRS_OFF_SPEED0)
                      && (haddr < `HRS_OFF_POS);
    assign status_w = {24'h0, state_r, err_dist_r | err_tmo_r, done_r} & 32'h0000_00FF
                      | {29'h0, err_dist_r, err_tmo_r, 1'b0} << 8;

    // read data for the word in the data phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ph_addr_r)
            `HRS_OFF_CTRL:   rd_mux = ctrl_r;
            `HRS_OFF_STATUS: rd_mux = status_w;
            `HRS_OFF_TMO:    rd_mux = tmo_r;
            `HRS_OFF_DIST:   rd_mux = dist_r;
            `HRS_OFF_OFFSET: rd_mux = offset_r;
            `HRS_OFF_POS:    rd_mux = actual_pos;
            `HRS_OFF_POSLIM: rd_mux = poslim_r;
            default:         rd_mux = sel_prof ? prof_rdata : 32'h0000_0000;
        endcase
    end

    // address phase capture; zero-wait answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_r   <= 1'b0;
            ph_rd_r   <= 1'b0;
            ph_addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ph_wr_r   <= a_valid && hwrite;
            ph_rd_r   <= a_valid && !hwrite;
            if (a_valid) begin
                ph_addr_r <= haddr;
            end
        end
    end

    assign hrdata = ph_rd_r ? rd_mux : 32'h0000_0000;

    // profile memory holds search, crawl and running settings
    logic [3:0]  ph_sel;
    logic [3:0]  prof_raddr;
    logic [1:0]  prof_seq_r;
    logic [31:0] cur_speed_r;
    logic [31:0] cur_accel_r;

    assign ph_sel     = (state_r == hrs_pkg::HRS_CRAWL) ? 4'h1 :
                        (state_r == hrs_pkg::HRS_RUN)   ? 4'h2 : 4'h0;
    assign prof_raddr = rd_prof ? rd_idx : ph_sel + {prof_seq_r, 1'b0} + {2'b0, prof_seq_r};

    hrs_profile_mem u_prof (
        .hclk    (hclk),
        .hresetn (hresetn),
        .we      (wr_now && sel_prof),
        .waddr   (prof_idx),
        .wdata   (hwdata),
        .raddr   (prof_raddr),
        .rdata   (prof_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // software registers
    logic tmo_hit;
    logic dist_hit;
    logic start_ev;
    logic target_hit;
    logic ref_act;
    logic idx_sel;
    logic idx_edge;
    logic ref_edge;
    logic [31:0] dist_lim;
    logic [31:0] step;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r   <= `HRS_CTRL_RST;
            tmo_r    <= `HRS_TMO_RST;
            dist_r   <= `HRS_DIST_RST;
            offset_r <= 32'h0000_0000;
            poslim_r <= 32'h7FFF_FFFF;
        end else begin
            ctrl_r[`HRS_C_START]    <= 1'b0;
            ctrl_r[`HRS_C_ABORT]    <= 1'b0;
            ctrl_r[`HRS_C_SAVE_ENC] <= 1'b0;
            if (wr_now && sel_ctrl) ctrl_r   <= hwdata;
            if (wr_now && sel_tmo)  tmo_r    <= hwdata;
            if (wr_now && sel_dist) dist_r   <= hwdata;
            if (wr_now && sel_off)  offset_r <= hwdata;
            if (wr_now && sel_lim)  poslim_r <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event decode
    assign ref_act   = in_s.ref_sw ^ ctrl_r[`HRS_C_REF_NC];
    assign idx_sel   = ctrl_r[`HRS_C_ALT_IDX] ? in_s.index_sec : in_s.index_main;
    assign idx_edge  = idx_sel && !idx_d_r;
    assign ref_edge  = !ref_act && ref_d_r;                                // falling edge
    assign dist_lim  = ctrl_r[`HRS_C_USE_LIM] ? poslim_r : dist_r;
    assign step      = (actual_pos >= last_pos_r) ? actual_pos - last_pos_r
                                                  : last_pos_r - actual_pos;
    assign tmo_hit   = ctrl_r[`HRS_C_TMO_EN] && (tmo_cnt_r >= tmo_r);
    assign dist_hit  = (dist_acc_r > dist_lim);
    // search target: limit, reference switch, stop or index edge
    always_comb begin
        unique case (ctrl_r[`HRS_C_TGT0 +: 2])
            2'h0:    target_hit = ctrl_r[`HRS_C_DIR_POS] ? in_s.limit_pos : in_s.limit_neg;
            2'h1:    target_hit = ref_act;
            2'h2:    target_hit = drv_r[2];
            default: target_hit = idx_edge;
        endcase
    end
    assign start_ev = ctrl_r[`HRS_C_START]
                      || (home_req_r && drv_r[0] && !en_d_r)
                      || (drv_r[1] && !comm_d_r && ctrl_r[`HRS_C_NO_COMMSIG]
                          && !ctrl_r[`HRS_C_NO_COMM]);

    ////////////////////////////////////////////////////////////////////////
    // phase sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hrs_pkg::HRS_IDLE, hrs_pkg::HRS_DONE, hrs_pkg::HRS_ERR: begin
                if (start_ev) state_nxt = hrs_pkg::HRS_SEARCH;
            end
            hrs_pkg::HRS_SEARCH: begin
                if (target_hit) state_nxt = hrs_pkg::HRS_CRAWL;
            end
            hrs_pkg::HRS_CRAWL: begin
                // crawl ends when the search target releases or the reference switch falls, or on the index edge when selected
                if (ctrl_r[`HRS_C_TGT0 +: 2] == 2'h3 ? idx_edge : ref_edge || !target_hit)
                    state_nxt = ctrl_r[`HRS_C_RTZ] ? hrs_pkg::HRS_RUN
                                                   : hrs_pkg::HRS_DONE;
            end
            hrs_pkg::HRS_RUN: begin
                // stop one count early: the move command lags the encoder a cycle
                if (actual_pos == 32'h0000_0000 || (move_active
                    && actual_pos == (move_dir_pos ? 32'hFFFF_FFFF : 32'h0000_0001)))
                    state_nxt = hrs_pkg::HRS_DONE;
            end
        endcase
        if ((state_r & (hrs_pkg::HRS_SEARCH | hrs_pkg::HRS_CRAWL | hrs_pkg::HRS_RUN)) != 6'h0
            && (tmo_hit || dist_hit || ctrl_r[`HRS_C_ABORT]))
            state_nxt = hrs_pkg::HRS_ERR;
    end

    // state, monitors and outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= hrs_pkg::HRS_IDLE;
            done_r <= 1'b0; err_tmo_r <= 1'b0; err_dist_r <= 1'b0;
            first_en_pend_r <= 1'b1; home_req_r <= 1'b0;
            tick_cnt_r <= 32'h0; tmo_cnt_r <= 32'h0; dist_acc_r <= 32'h0;
            start_pos_r <= 32'h0; last_pos_r <= 32'h0;
            en_d_r <= 1'b0; comm_d_r <= 1'b0; idx_d_r <= 1'b0; ref_d_r <= 1'b0;
            prof_seq_r <= 2'h0; cur_speed_r <= 32'h0; cur_accel_r <= 32'h0;
            move_active <= 1'b0; move_dir_pos <= 1'b0; move_speed <= 32'h0;
            move_accel <= 32'h0; move_jerk <= 32'h0; move_target <= 32'h0;
            move_to_target <= 1'b0; pos_set <= 1'b0; pos_set_value <= 32'h0;
            sync_disable <= 1'b0; homing_done <= 1'b0; homing_error <= 1'b0;
            enc_offset_save <= 1'b0; enc_offset_value <= 32'h0;
        end else begin
            state_r <= state_nxt;
            en_d_r <= drv_r[0]; comm_d_r <= drv_r[1];
            idx_d_r <= idx_sel; ref_d_r <= ref_act;
            last_pos_r <= actual_pos;
            // first enable after power-up arms homing once
            if (drv_r[0] && !en_d_r) first_en_pend_r <= 1'b0;
            home_req_r <= first_en_pend_r && ctrl_r[`HRS_C_HOME_EN];
            if (start_ev) begin
                tick_cnt_r <= 32'h0; tmo_cnt_r <= 32'h0; dist_acc_r <= 32'h0;
                done_r <= 1'b0; err_tmo_r <= 1'b0; err_dist_r <= 1'b0;
                start_pos_r <= actual_pos;
            end else if (state_r == hrs_pkg::HRS_SEARCH || state_r == hrs_pkg::HRS_CRAWL
                         || state_r == hrs_pkg::HRS_RUN) begin
                dist_acc_r <= dist_acc_r + step;
                // timeout counted in 10 ms ticks
                if (tick_cnt_r >= TICK_CYC - 1) begin
                    tick_cnt_r <= 32'h0;
                    tmo_cnt_r  <= tmo_cnt_r + 32'h1;
                end else begin
                    tick_cnt_r <= tick_cnt_r + 32'h1;
                end
            end
            if (state_nxt == hrs_pkg::HRS_ERR && state_r != hrs_pkg::HRS_ERR) begin
                err_tmo_r  <= tmo_hit;
                err_dist_r <= dist_hit;
            end
            if (state_nxt == hrs_pkg::HRS_DONE && state_r != hrs_pkg::HRS_DONE)
                done_r <= 1'b1;
            // cycle the profile word fetch: speed, accel, jerk
            prof_seq_r <= (prof_seq_r == 2'h2) ? 2'h0 : prof_seq_r + 2'h1;
            unique case (prof_seq_r)
                2'h0: cur_speed_r <= prof_rdata;
                2'h1: cur_accel_r <= prof_rdata;
                default: begin
                    move_speed <= cur_speed_r;
                    move_accel <= cur_accel_r;
                    move_jerk  <= prof_rdata;
                end
            endcase
            move_active  <= (state_nxt & (hrs_pkg::HRS_SEARCH | hrs_pkg::HRS_CRAWL
                                          | hrs_pkg::HRS_RUN)) != 6'h0 && !pos_set
                            && !(state_r == hrs_pkg::HRS_CRAWL && state_nxt == hrs_pkg::HRS_RUN);
            move_dir_pos <= (state_nxt == hrs_pkg::HRS_CRAWL) ? !ctrl_r[`HRS_C_DIR_POS] :
                (state_nxt == hrs_pkg::HRS_RUN) ? offset_r[31] : ctrl_r[`HRS_C_DIR_POS];
            move_to_target <= (state_nxt == hrs_pkg::HRS_RUN);
            move_target    <= 32'h0000_0000;
            // reference found: position becomes the offset value
            pos_set       <= (state_r == hrs_pkg::HRS_CRAWL) && (state_nxt != state_r)
                             && (state_nxt != hrs_pkg::HRS_ERR);
            pos_set_value <= offset_r;
            sync_disable  <= ctrl_r[`HRS_C_NO_SYNC] && ((state_nxt & (hrs_pkg::HRS_SEARCH
                             | hrs_pkg::HRS_CRAWL | hrs_pkg::HRS_RUN)) != 6'h0);
            homing_done   <= done_r && !start_ev;
            homing_error  <= (err_tmo_r | err_dist_r) && !start_ev;
            enc_offset_save  <= ctrl_r[`HRS_C_SAVE_ENC] && done_r;
            enc_offset_value <= start_pos_r - actual_pos + offset_r;
        end
    end
endmodule : hrs_sequencer
`default_nettype wire

/* hrs_map.svh */
// Purpose: constants for the homing run sequencer
// Assumes: 40 MHz hclk, AHB-Lite word registers
// Notes:   offsets are byte addresses
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH
`define HRS_OFF_CTRL     12'h000
`define HRS_OFF_STATUS   12'h004
`define HRS_OFF_TMO      12'h008
`define HRS_OFF_DIST     12'h00C
`define HRS_OFF_OFFSET   12'h010
`define HRS_OFF_SPEED0   12'h014
`define HRS_OFF_ACCEL0   12'h020
`define HRS_OFF_JERK0    12'h02C
`define HRS_OFF_POS      12'h038
`define HRS_OFF_POSLIM   12'h03C
`define HRS_C_START      0
`define HRS_C_HOME_EN    1
`define HRS_C_RTZ        2
`define HRS_C_ALT_IDX    3
`define HRS_C_TMO_EN     4
`define HRS_C_NO_COMM    5
`define HRS_C_NO_SYNC    6
`define HRS_C_REF_NC     7
`define HRS_C_USE_LIM    8
`define HRS_C_NO_COMMSIG 9
`define HRS_C_DIR_POS    10
`define HRS_C_TGT0       11
`define HRS_C_SAVE_ENC   13
`define HRS_C_ABORT      14
`define HRS_CTRL_RST     32'h0000_0000
`define HRS_TICK_NS      10000000
`define HRS_CLK_NS       25
`define HRS_TICK_CYC     (`HRS_TICK_NS / `HRS_CLK_NS)
`define HRS_TMO_RST      32'h0000_1770
`define HRS_DIST_RST     32'h0001_86A0
`endif

/* hrs_pkg.sv */
// Purpose: types for the homing run sequencer
// Assumes: nothing
// Notes:   one-hot phase codes
package hrs_pkg;
    typedef enum logic [5:0] {
        HRS_IDLE   = 6'h01,
        HRS_SEARCH = 6'h02,
        HRS_CRAWL  = 6'h04,
        HRS_RUN    = 6'h08,
        HRS_DONE   = 6'h10,
        HRS_ERR    = 6'h20
    } hrs_state_e;
    typedef struct packed {
        logic [31:0] speed;
        logic [31:0] accel;
        logic [31:0] jerk;
    } hrs_profile_s;
    typedef struct packed {
        logic limit_pos;
        logic limit_neg;
        logic ref_sw;
        logic index_main;
        logic index_sec;
    } hrs_inputs_s;
endpackage : hrs_pkg

/* hrs_profile_mem.sv */
// Purpose: per-phase motion profile storage
// Assumes: one write port, one registered read port
// Notes:   three phases by three words
`timescale 1ns/1ps
`default_nettype none
module hrs_profile_mem (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  raddr,
    output logic      [31:0] rdata
);
    logic [31:0] mem_r [0:8];

    // storage write, word read out of a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 9; i++) begin
                mem_r[i] <= 32'h0000_0000;
            end
            rdata <= 32'h0000_0000;
        end else begin
            if (we && waddr < 4'h9) begin
                mem_r[waddr] <= wdata;
            end
            rdata <= (raddr < 4'h9) ? mem_r[raddr] : 32'h0000_0000;
        end
    end
endmodule : hrs_profile_mem
`default_nettype wire

/* hrs_sequencer_checker.sv */
// Purpose: port-level assertions for the homing sequencer
// Assumes: one clock domain, word transfers only
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module hrs_sequencer_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        move_active,
    input wire logic        pos_set,
    input wire logic        homing_done,
    input wire logic        homing_error,
    input wire logic        enc_offset_save
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // bus and run status relations
    AST_NO_WAIT: assert property (hreadyout && !hresp) else $error("bus stalled or erred");
    AST_UNMAPPED: assert property (hsel && hready && htrans == 2'h2 && !hwrite
        && haddr == 12'hFFC |=> hrdata == 32'h0) else $error("unmapped read not zero");
    AST_DONE_XOR: assert property (!(homing_done && homing_error))
        else $error("done and error together");
    AST_DONE_STILL: assert property (homing_done |-> !move_active)
        else $error("axis moving while done");
    AST_ERR_STOP: assert property ($rose(homing_error) |-> ##[0:2] !move_active)
        else $error("axis not stopped after error");
    AST_REF_PULSE: assert property (pos_set |=> !pos_set)
        else $error("position set longer than one cycle");
    AST_SAVE_PULSE: assert property (enc_offset_save |=> !enc_offset_save)
        else $error("offset save longer than one cycle");
    AST_SET_OK: assert property (pos_set |-> !homing_error)
        else $error("position set during error");
    // main scenarios reached
    cover property (pos_set);
    cover property ($rose(homing_done));
    cover property ($rose(homing_error));
endmodule : hrs_sequencer_checker
bind hrs_sequencer hrs_sequencer_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .move_active(move_active), .pos_set(pos_set),
    .homing_done(homing_done), .homing_error(homing_error), .enc_offset_save(enc_offset_save));
`default_nettype wire

/* hrs_axis_model.sv */
// Purpose: motor, encoder and switch model for the sequencer
// Assumes: one count per cycle while moving
// Notes:   limits at plus and minus LIM, stop at the positive limit
`timescale 1ns/1ps
`default_nettype none
module hrs_axis_model #(
    parameter int LIM = 400
) (
    input  wire logic           hclk,
    input  wire logic           move_active,
    input  wire logic           move_dir_pos,
    input  wire logic           pos_set,
    input  wire logic [31:0]    pos_set_value,
    input  wire logic           ref_nc,
    output logic      [31:0]    actual_pos,
    output hrs_pkg::hrs_inputs_s pins,
    output logic                load_rise
);
    int pos = 0;
    // encoder follows the commanded motion or a reference load
    always @(posedge hclk) begin
        if (pos_set === 1'b1)
            pos <= int'(pos_set_value);
        else if (move_active === 1'b1)
            pos <= (move_dir_pos === 1'b1) ? pos + 1 : pos - 1;
    end
    // switches and index tracks derived from position
    assign actual_pos = 32'(pos);
    assign pins = '{pos >= LIM, pos <= -LIM, (pos >= 100 && pos < 116) ^ ref_nc,
                    pos % 64 == 0, pos % 64 == 32};
    assign load_rise = pos >= LIM;
endmodule : hrs_axis_model
`default_nettype wire

/* hrs_sequencer_tb.sv */
// Purpose: self-checking bench for the homing sequencer
// Assumes: tick shortened to 10 cycles
// Notes:   register shadow kept in mdl
`timescale 1ns/1ps
`default_nettype none
`include "hrs_map.svh"
module hrs_sequencer_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        drive_enable = 1'b0;
    logic        comm_found = 1'b0;
    logic [31:0] hrdata, actual_pos, pos_set_value, seen_set, off, st;
    logic        hreadyout, move_active, move_dir_pos, pos_set, sync_disable;
    logic        homing_done, homing_error, load_rise;
    hrs_pkg::hrs_inputs_s pins;
    logic [31:0] mdl [0:1023];
    logic [11:0] ra [4] = '{12'h000, 12'h008, 12'h00C, 12'hFFC};
    int          n_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          seed = 32'h6DA7;
    int          n;
    hrs_sequencer #(.TICK_CYC(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .limit_pos(pins.limit_pos), .limit_neg(pins.limit_neg), .ref_switch(pins.ref_sw),
        .index_main(pins.index_main), .secondary_index_track_input(pins.index_sec),
        .drive_enable(drive_enable), .commutation_found(comm_found),
        .load_integral_rise(load_rise),
        .actual_pos(actual_pos), .move_active(move_active), .move_dir_pos(move_dir_pos),
        .move_speed(), .move_accel(), .move_jerk(), .move_target(), .move_to_target(),
        .pos_set(pos_set), .pos_set_value(pos_set_value), .sync_disable(sync_disable),
        .homing_done(homing_done), .homing_error(homing_error), .enc_offset_save(),
        .enc_offset_value());
    hrs_axis_model axis_u (.hclk(hclk), .move_active(move_active), .move_dir_pos(move_dir_pos),
        .pos_set(pos_set), .pos_set_value(pos_set_value), .ref_nc(1'b0),
        .actual_pos(actual_pos), .pins(pins), .load_rise(load_rise));
    initial forever #12.5 hclk = ~hclk;
    // last reference value handed to the encoder
    always @(posedge hclk) if (pos_set === 1'b1) seen_set <= pos_set_value;
    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // single word bus cycles, address phase then data phase
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        if (w) mdl[a[11:2]] = d;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, st);
    endtask : wr
    task automatic wait_end(input logic sync_on, output int cnt);
        cnt = 0;
        repeat (4) @(posedge hclk);
        while (homing_done !== 1'b1 && homing_error !== 1'b1 && cnt < 3000) begin
            @(posedge hclk);
            cnt++;
            if (sync_on && move_active === 1'b1) chk(sync_disable, 32'h1);
        end
    endtask : wait_end
    task automatic tally_and_finish;
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 1024; i++) mdl[i] = 32'h0;
        mdl[2] = `HRS_TMO_RST;
        mdl[3] = `HRS_DIST_RST;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, unmapped word, profile and offset readback
        foreach (ra[i]) begin
            bus(ra[i], 1'b0, 32'h0, st);
            chk(st, mdl[ra[i][11:2]]);
        end
        for (int k = 0; k < 9; k++) begin
            wr(12'h014 + 12'(4 * k), $random(seed));
            bus(12'h014 + 12'(4 * k), 1'b0, 32'h0, st);
            chk(st, mdl[5 + k]);
        end
        off = $random(seed) & 32'hFF;
        wr(`HRS_OFF_OFFSET, off);
        bus(`HRS_OFF_OFFSET, 1'b0, 32'h0, st);
        chk(st, off);
        // home on first enable with return to zero
        wr(`HRS_OFF_CTRL, 32'h406);
        repeat (20) @(posedge hclk);
        chk(move_active, 32'h0);
        drive_enable <= 1'b1;
        wait_end(1'b0, n);
        chk(homing_done, 32'h1);
        chk(actual_pos, 32'h0);
        // started run without return, sync suppressed
        wr(`HRS_OFF_CTRL, 32'h441);
        wait_end(1'b1, n);
        chk(seen_set, off);
        chk(actual_pos, off);
        bus(`HRS_OFF_STATUS, 1'b0, 32'h0, st);
        chk(st & 32'h603, 32'h1);
        // commutation found on a drive without its signals starts a run
        comm_found <= 1'b1;
        wr(`HRS_OFF_CTRL, 32'h200);
        wait_end(1'b0, n);
        chk({n > 100, homing_done}, 32'h3);
        // search distance exceeded
        wr(`HRS_OFF_DIST, 32'h32);
        wr(`HRS_OFF_CTRL, 32'h1);
        wait_end(1'b0, n);
        bus(`HRS_OFF_STATUS, 1'b0, 32'h0, st);
        chk(st & 32'h603, 32'h402);
        // timeout after three ticks, distance error cleared
        wr(`HRS_OFF_DIST, `HRS_DIST_RST);
        wr(`HRS_OFF_TMO, 32'h3);
        wr(`HRS_OFF_CTRL, 32'h11);
        wait_end(1'b0, n);
        bus(`HRS_OFF_STATUS, 1'b0, 32'h0, st);
        chk(st & 32'h603, 32'h202);
        chk({30'h0, n >= 20, n <= 45}, 32'h3);
        tally_and_finish();
    end
endmodule : hrs_sequencer_tb
`default_nettype wire
